// File: cpc_defines.svh
// offsets, field positions, reset values and constants for the cache policy block
// assumes inclusion by the top module only
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPC_OFF_SCR0    8'h00
`define CPC_OFF_PBCR    8'h04
`define CPC_OFF_ECR     8'h08
`define CPC_OFF_AFR     8'h0c
`define CPC_OFF_REGION  8'h10
`define CPC_OFF_PTABLE  8'h14
`define CPC_OFF_CFG     8'h18
`define CPC_OFF_STATUS  8'h1c
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPC_SCR0_PG     31
`define CPC_SCR0_CD     30
`define CPC_SCR0_NW     29
`define CPC_PBCR_PCD    4
`define CPC_PBCR_PWT    3
`define CPC_ECR_PGE     7
`define CPC_AFR_L3D     6
`define CPC_CFG_NOCOH   0
`define CPC_CFG_DUAL    1
// ----------------------------------------
// reset values: cd and nw set after reset
// ----------------------------------------
`define CPC_SCR0_RST    32'h6000_0000
`define CPC_REGION_RST  32'h0000_0000
`define CPC_PTABLE_RST  32'h0000_0000
`define CPC_CFG_RST     32'h0000_0001
`define CPC_REGION_N    4
`endif

// File: cpc_pkg.sv
// types shared by the cache policy block
// assumes cpc_defines.svh is present in the same folder
package cpc_pkg;
   // memory types, one code per caching method
   typedef enum logic [2:0]
   {
      MT_UC = 3'h0,
      MT_WC = 3'h1,
      MT_WT = 3'h4,
      MT_WP = 3'h5,
      MT_WB = 3'h6
   } cpc_mtype_t;

   // per access request from the core pipeline
   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic        hit;
      logic        shared;
      logic        exclusive;
      logic        pte_pcd;
      logic        pte_pwt;
      logic        pte_glb;
      logic        is_dir;
      logic [1:0]  region;
      logic [2:0]  ptab_idx;
   } cpc_acc_t;

   // per access decision
   typedef struct packed
   {
      logic        valid;
      logic        cacheable;
      logic        write_through;
      logic        allocate;
      logic        to_memory;
      logic        upgrade_mod;
      logic        keep_shared;
      logic        l3_enable;
      logic        tlb_keep;
      logic        pin_pcd;
      logic        pin_pwt;
      cpc_mtype_t  mtype;
   } cpc_dec_t;

   // snoop request and answer
   typedef struct packed
   {
      logic        valid;
      logic        par_err;
      logic        invalidate;
   } cpc_snp_t;

   // axi state machine
   typedef enum logic [2:0]
   {
      AX_IDLE = 3'b001,
      AX_BRSP = 3'b010,
      AX_RRSP = 3'b100
   } cpc_axst_t;

   // whole module state
   typedef struct packed
   {
      logic [31:0] scr0;
      logic [31:0] pbcr;
      logic [31:0] ecr;
      logic [31:0] afr;
      logic [31:0] region;
      logic [31:0] ptable;
      logic [31:0] cfg;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      cpc_axst_t   st;
      logic [1:0]  bresp;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      cpc_dec_t    dec;
      cpc_snp_t    snp;
      logic        address_parity_error_pin;
      logic [15:0] nacc;
   } cpc_state_t;
endpackage : cpc_pkg

// File: cpc_top.sv
// cache policy control: register file over axi4-lite and per access policy decision
// assumes one 100 MHz clock; access and snoop inputs synchronous to it
`timescale 1ns/1ps
`include "cpc_defines.svh"

// What this block does
// - cd and nw both set: no coherency, reset state
// - no coherency: read hits served, misses never allocate
// - no coherency: write hit updates, exclusive becomes modified
// - no coherency: shared line stays shared on write
// - no coherency: write miss goes to memory, no allocate
// - no coherency: snoops never invalidate; flush instructions still do
// - no coherency: first level ignores snoops; outer levels accept them only if dual
// - without no-coherency mode, cd selects no-fill mode
// - write policy at bit 29; clear bits give write-back
// - level one off: dual accepts, single inhibits snoops
// - inhibited snoops skip parity; accepted ones check it
// - page uncached acts with paging on and cd clear
// - page write-through acts with paging on, nw clear
// - page base bits govern only the page directory
// - persistent pages kept only when enable bit set
// - region types assign caching per physical range
// - page table types refine region typing per page
// - bit 6 disables the third level cache alone
// - external cacheable and write pins honoured per access
// - uncached and write-through pins follow page bits
// - whichever control forbids caching wins
module cpc_top
(
   input  wire logic              CLK_I,
   input  wire logic              RST_N_I,
   input  wire logic [7:0]        S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   input  wire logic [7:0]        S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I,
   input  wire cpc_pkg::cpc_acc_t ACC_I,
   input  wire logic              EXT_CACHEABLE_N_I,
   input  wire logic              EXT_WRITE_BACK_I,
   input  wire logic              FLUSH_INSTR_I,
   input  wire logic              SNOOP_VALID_I,
   input  wire logic              SNOOP_PAR_ERR_I,
   output cpc_pkg::cpc_dec_t      DEC_O,
   output cpc_pkg::cpc_snp_t      SNOOP_O,
   output logic                   L1_INVALIDATE_O,
   output logic                   ADDR_PAR_ERR_N_O
);
   // ----------------------------------------
   // state and helpers
   // ----------------------------------------
   cpc_pkg::cpc_state_t s_r;
   cpc_pkg::cpc_state_t s_nxt;

   // byte-lane merge used by every writable register
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // pick a 3-bit type out of a packed table of types
   function automatic cpc_pkg::cpc_mtype_t tsel(input logic [31:0] tab, input logic [2:0] i);
      logic [2:0] v;
      v = 3'(tab >> ({2'h0, i} * 6'h04));
      return cpc_pkg::cpc_mtype_t'(v);
   endfunction

   // combine two types: uncached beats all, then write-combining, write-through, write-protect, write-back last
   function automatic cpc_pkg::cpc_mtype_t tmin(input cpc_pkg::cpc_mtype_t a,
                                               input cpc_pkg::cpc_mtype_t b);
      cpc_pkg::cpc_mtype_t r;
      if (a == cpc_pkg::MT_UC || b == cpc_pkg::MT_UC)
      begin
         r = cpc_pkg::MT_UC;
      end
      else if (a == cpc_pkg::MT_WC || b == cpc_pkg::MT_WC)
      begin
         r = cpc_pkg::MT_WC;
      end
      else if (a == cpc_pkg::MT_WT || b == cpc_pkg::MT_WT)
      begin
         r = cpc_pkg::MT_WT;
      end
      else if (a == cpc_pkg::MT_WP || b == cpc_pkg::MT_WP)
      begin
         r = cpc_pkg::MT_WP;
      end
      else
      begin
         r = cpc_pkg::MT_WB;
      end
      return r;
   endfunction

   logic cd;
   logic nw;
   logic pg;
   logic nocoh;
   logic nocoh_impl;
   logic nofill;
   logic eff_pcd;
   logic eff_pwt;
   logic snoop_ok;
   cpc_pkg::cpc_mtype_t t_reg;
   cpc_pkg::cpc_mtype_t t_page;
   cpc_pkg::cpc_mtype_t t_eff;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      // global controls as held at this access start
      pg         = s_r.scr0[`CPC_SCR0_PG];
      cd         = s_r.scr0[`CPC_SCR0_CD];
      nw         = s_r.scr0[`CPC_SCR0_NW];
      nocoh_impl = s_r.cfg[`CPC_CFG_NOCOH];
      nocoh      = cd && nw && nocoh_impl;
      nofill     = cd && !nocoh;

      // page bits: directory uses page base reg, else entry bits
      eff_pcd = ACC_I.is_dir ? s_r.pbcr[`CPC_PBCR_PCD] : ACC_I.pte_pcd;
      eff_pwt = ACC_I.is_dir ? s_r.pbcr[`CPC_PBCR_PWT] : ACC_I.pte_pwt;

      // region type, then per page type, then page bits; most limiting wins
      t_reg  = tsel(s_r.region, {1'b0, ACC_I.region});
      t_page = tsel(s_r.ptable, ACC_I.ptab_idx);
      t_eff  = tmin(t_reg, t_page);
      if (pg && !cd && eff_pcd)
      begin
         t_eff = cpc_pkg::MT_UC;
      end
      if (pg && !nw && eff_pwt)
      begin
         t_eff = tmin(t_eff, cpc_pkg::MT_WT);
      end
      if (EXT_CACHEABLE_N_I)
      begin
         t_eff = cpc_pkg::MT_UC;
      end
      else if (!EXT_WRITE_BACK_I)
      begin
         t_eff = tmin(t_eff, cpc_pkg::MT_WT);
      end

      // per access decision, registered
      s_nxt.dec.valid         = ACC_I.valid;
      s_nxt.dec.mtype         = t_eff;
      s_nxt.dec.cacheable     = !cd && t_eff != cpc_pkg::MT_UC;
      s_nxt.dec.write_through = nw ? 1'b0 : (t_eff == cpc_pkg::MT_WT);
      s_nxt.dec.allocate      = ACC_I.valid && !ACC_I.hit && !cd
                                && t_eff != cpc_pkg::MT_UC;
      s_nxt.dec.to_memory     = ACC_I.valid && ACC_I.write
                                && (!ACC_I.hit || s_nxt.dec.write_through);
      s_nxt.dec.upgrade_mod   = ACC_I.valid && ACC_I.write && ACC_I.hit
                                && ACC_I.exclusive;
      s_nxt.dec.keep_shared   = ACC_I.valid && ACC_I.write && ACC_I.hit
                                && ACC_I.shared && nocoh;
      s_nxt.dec.l3_enable     = !s_r.afr[`CPC_AFR_L3D] && s_nxt.dec.cacheable;
      s_nxt.dec.tlb_keep      = ACC_I.pte_glb && s_r.ecr[`CPC_ECR_PGE];
      s_nxt.dec.pin_pcd       = eff_pcd;
      s_nxt.dec.pin_pwt       = eff_pwt;
      if (ACC_I.valid)
      begin
         s_nxt.nacc = s_r.nacc + 16'h0001;
      end

      // snoops: l1 blind in no-coherency; outer levels see it only with dual set
      snoop_ok = !nocoh || s_r.cfg[`CPC_CFG_DUAL];
      s_nxt.snp.valid      = SNOOP_VALID_I && snoop_ok;
      s_nxt.snp.par_err    = SNOOP_VALID_I && snoop_ok && SNOOP_PAR_ERR_I;
      s_nxt.snp.invalidate = SNOOP_VALID_I && !nocoh && !SNOOP_PAR_ERR_I;
      s_nxt.address_parity_error_pin          = s_nxt.snp.par_err;

      // axi write: address and data taken in either order
      if (S_AXI_AWVALID_I && !s_r.aw_got && s_r.st == cpc_pkg::AX_IDLE)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !s_r.w_got && s_r.st == cpc_pkg::AX_IDLE)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = S_AXI_WDATA_I;
         s_nxt.wstrb = S_AXI_WSTRB_I;
      end
      unique case (s_r.st)
         cpc_pkg::AX_IDLE:
         begin
            if (s_r.aw_got && s_r.w_got)
            begin
               s_nxt.aw_got = 1'b0;
               s_nxt.w_got  = 1'b0;
               s_nxt.bresp  = 2'h0;
               s_nxt.st     = cpc_pkg::AX_BRSP;
               unique case (s_r.awaddr)
                  `CPC_OFF_SCR0:   s_nxt.scr0   = wmerge(s_r.scr0, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_PBCR:   s_nxt.pbcr   = wmerge(s_r.pbcr, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_ECR:    s_nxt.ecr    = wmerge(s_r.ecr, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_AFR:    s_nxt.afr    = wmerge(s_r.afr, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_REGION: s_nxt.region = wmerge(s_r.region, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_PTABLE: s_nxt.ptable = wmerge(s_r.ptable, s_r.wdata, s_r.wstrb);
                  `CPC_OFF_CFG:    s_nxt.cfg    = wmerge(s_r.cfg, s_r.wdata, s_r.wstrb);
                  default:         s_nxt.bresp  = 2'h2;               // unmapped or read-only
               endcase
            end
            else if (S_AXI_ARVALID_I)
            begin
               s_nxt.rresp = 2'h0;
               s_nxt.st    = cpc_pkg::AX_RRSP;
               unique case (S_AXI_ARADDR_I)
                  `CPC_OFF_SCR0:   s_nxt.rdata = s_r.scr0;
                  `CPC_OFF_PBCR:   s_nxt.rdata = s_r.pbcr;
                  `CPC_OFF_ECR:    s_nxt.rdata = s_r.ecr;
                  `CPC_OFF_AFR:    s_nxt.rdata = s_r.afr;
                  `CPC_OFF_REGION: s_nxt.rdata = s_r.region;
                  `CPC_OFF_PTABLE: s_nxt.rdata = s_r.ptable;
                  `CPC_OFF_CFG:    s_nxt.rdata = s_r.cfg;
                  `CPC_OFF_STATUS: s_nxt.rdata = {s_r.nacc, 12'h000, nofill, nocoh,
                                                  s_r.address_parity_error_pin, snoop_ok};
                  default:
                  begin
                     s_nxt.rdata = 32'h0000_0000;
                     s_nxt.rresp = 2'h2;
                  end
               endcase
            end
         end
         cpc_pkg::AX_BRSP:
         begin
            if (S_AXI_BREADY_I)
            begin
               s_nxt.st = cpc_pkg::AX_IDLE;
            end
         end
         cpc_pkg::AX_RRSP:
         begin
            if (S_AXI_RREADY_I)
            begin
               s_nxt.st = cpc_pkg::AX_IDLE;
            end
         end
         default:
         begin
            s_nxt.st = cpc_pkg::AX_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         s_r        <= '0;
         s_r.scr0   <= `CPC_SCR0_RST;
         s_r.region <= `CPC_REGION_RST;
         s_r.ptable <= `CPC_PTABLE_RST;
         s_r.cfg    <= `CPC_CFG_RST;
         s_r.st     <= cpc_pkg::AX_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // ready only while idle and slot free; keeps one write, one read in flight
   assign S_AXI_AWREADY_O  = s_r.st == cpc_pkg::AX_IDLE && !s_r.aw_got;
   assign S_AXI_WREADY_O   = s_r.st == cpc_pkg::AX_IDLE && !s_r.w_got;
   assign S_AXI_ARREADY_O  = s_r.st == cpc_pkg::AX_IDLE && !(s_r.aw_got && s_r.w_got);
   assign S_AXI_BVALID_O   = s_r.st == cpc_pkg::AX_BRSP;
   assign S_AXI_BRESP_O    = s_r.bresp;
   assign S_AXI_RVALID_O   = s_r.st == cpc_pkg::AX_RRSP;
   assign S_AXI_RDATA_O    = s_r.rdata;
   assign S_AXI_RRESP_O    = s_r.rresp;
   assign DEC_O            = s_r.dec;
   assign SNOOP_O          = s_r.snp;
   assign L1_INVALIDATE_O  = FLUSH_INSTR_I;
   assign ADDR_PAR_ERR_N_O = !s_r.address_parity_error_pin;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic nocoh_q;
   assign nocoh_q = s_r.scr0[`CPC_SCR0_CD] && s_r.scr0[`CPC_SCR0_NW] && s_r.cfg[`CPC_CFG_NOCOH];

   sequence s_miss_nocoh;
      ACC_I.valid && !ACC_I.hit && nocoh_q;
   endsequence

   a_nocoh_no_alloc: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      s_miss_nocoh |=> !DEC_O.allocate) else $error("allocation in no-coherency mode");
   a_excl_to_mod: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      ACC_I.valid && ACC_I.write && ACC_I.hit && ACC_I.exclusive |=> DEC_O.upgrade_mod)
      else $error("exclusive line not marked modified");
   a_shared_kept: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      ACC_I.valid && ACC_I.write && ACC_I.hit && ACC_I.shared && nocoh_q
      |=> DEC_O.keep_shared) else $error("shared line not kept");
   a_wmiss_memory: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      ACC_I.valid && !ACC_I.hit && nocoh_q && ACC_I.write
      |=> DEC_O.to_memory && !DEC_O.allocate)
      else $error("write miss not sent to memory");
   a_snoop_no_inv: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      nocoh_q |=> !SNOOP_O.invalidate) else $error("snoop invalidated line");
   a_single_inhib: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      nocoh_q && !s_r.cfg[`CPC_CFG_DUAL] |=> !SNOOP_O.valid && ADDR_PAR_ERR_N_O)
      else $error("snoop accepted in single system");
   a_parity_flag: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      SNOOP_VALID_I && SNOOP_PAR_ERR_I && !nocoh_q |=> !ADDR_PAR_ERR_N_O)
      else $error("parity error not flagged");
   a_uncached_win: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      ACC_I.valid && EXT_CACHEABLE_N_I |=> DEC_O.mtype == cpc_pkg::MT_UC && !DEC_O.cacheable)
      else $error("uncached designation overridden");
   a_l3_disable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      s_r.afr[`CPC_AFR_L3D] |=> !DEC_O.l3_enable) else $error("l3 enabled while disabled");
endmodule // cpc_top

// File: cpc_ext_agent.sv
// far side model: external cache pins and a snooping bus agent
// assumes one clock; requests from the bench change just after a rising edge
`timescale 1ns/1ps
module cpc_ext_agent
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic acc_valid_i,
   input  wire logic uc_mode_i,
   input  wire logic wt_mode_i,
   input  wire logic snoop_req_i,
   input  wire logic snoop_bad_i,
   output logic      ext_cacheable_n_o,
   output logic      ext_write_back_o,
   output logic      snoop_valid_o,
   output logic      snoop_par_err_o
);
   logic t_r;
   // pins toggle outside accesses: nothing stale may pass for an answer
   assign ext_cacheable_n_o = acc_valid_i ? uc_mode_i : t_r;
   assign ext_write_back_o  = acc_valid_i ? ~wt_mode_i : ~t_r;
   // one-cycle snoop pulse per bench request
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         t_r             <= 1'b0;
         snoop_valid_o   <= 1'b0;
         snoop_par_err_o <= 1'b0;
      end
      else
      begin
         t_r             <= ~t_r;
         snoop_valid_o   <= snoop_req_i;
         snoop_par_err_o <= snoop_req_i ? snoop_bad_i : ~snoop_par_err_o;
      end
   end
endmodule // cpc_ext_agent

// File: cache_policy_control_tb.sv
// self-checking bench for cpc_top: axi4-lite tasks, access and snoop tasks
// assumes cpc_pkg compiled first and the far side model cpc_ext_agent
`timescale 1ns/1ps
module cache_policy_control_tb;
   logic clk = 1'b0, rst_n = 1'b0;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
   logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, ext_n, ext_wb, s_v, s_pe, l1_inv, pe_n;
   logic [31:0] w_d = 32'h0, r_d;
   logic [1:0] b_resp, r_resp;
   logic uc_m = 1'b0, wt_m = 1'b0, s_req = 1'b0, s_bad = 1'b0, flush = 1'b0;
   cpc_pkg::cpc_acc_t acc_r = '0;
   cpc_pkg::cpc_dec_t dec;
   cpc_pkg::cpc_snp_t snp;
   int miscompares = 0, checked = 0;
   always #5 clk = ~clk;
   cpc_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(aw_a),
      .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(w_d),
      .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
      .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_rdy),
      .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
      .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_v),
      .S_AXI_RREADY_I(r_rdy), .ACC_I(acc_r), .EXT_CACHEABLE_N_I(ext_n),
      .EXT_WRITE_BACK_I(ext_wb), .FLUSH_INSTR_I(flush), .SNOOP_VALID_I(s_v),
      .SNOOP_PAR_ERR_I(s_pe), .DEC_O(dec), .SNOOP_O(snp),
      .L1_INVALIDATE_O(l1_inv), .ADDR_PAR_ERR_N_O(pe_n));
   cpc_ext_agent agent_u (.clk_i(clk), .rst_n_i(rst_n), .acc_valid_i(acc_r.valid),
      .uc_mode_i(uc_m), .wt_mode_i(wt_m), .snoop_req_i(s_req), .snoop_bad_i(s_bad),
      .ext_cacheable_n_o(ext_n), .ext_write_back_o(ext_wb), .snoop_valid_o(s_v),
      .snoop_par_err_o(s_pe));
   task conclude();
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   // readies and answers sampled mid-cycle hold their value at the next edge
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic done, aw_t, w_t;
      logic [1:0] rs;
      done = 1'b0;
      @(posedge clk);
      aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_rdy <= 1'b1;
      for (n = 0; n < 64 && !done; n++)
      begin
         @(negedge clk);
         aw_t = aw_v && aw_rdy; w_t = w_v && w_rdy; done = b_v; rs = b_resp;
         @(posedge clk);
         if (aw_t) aw_v <= 1'b0;
         if (w_t) w_v <= 1'b0;
         if (done) b_rdy <= 1'b0;
      end
      if (done) chk_word("bresp", {30'h0, er}, {30'h0, rs});
      else begin miscompares++; conclude(); end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
           input logic [1:0] er);
      int n;
      logic done, ar_t;
      logic [31:0] dv;
      logic [1:0] rs;
      done = 1'b0;
      @(posedge clk);
      ar_a <= a; ar_v <= 1'b1; r_rdy <= 1'b1;
      for (n = 0; n < 64 && !done; n++)
      begin
         @(negedge clk);
         ar_t = ar_v && ar_rdy; done = r_v; dv = r_d; rs = r_resp;
         @(posedge clk);
         if (ar_t) ar_v <= 1'b0;
         if (done) r_rdy <= 1'b0;
      end
      if (!done) begin miscompares++; conclude(); end
      else begin chk_word("rdata", e, dv & m); chk_word("rresp", {30'h0, er}, {30'h0, rs}); end
   endtask
   // f: write hit shared exclusive pcd pwt global dir; decision stands next cycle
   task acc(input logic [7:0] f);
      @(posedge clk);
      acc_r <= {1'b1, f, 5'h00};
      @(posedge clk);
      acc_r <= '0;
      #1;
   endtask
   task snoop(input logic bad);
      @(posedge clk);
      s_req <= 1'b1; s_bad <= bad;
      @(posedge clk);
      s_req <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h6000_0000, 32'hffff_ffff, 2'h0);
      rd(8'h1c, 32'h4, 32'h4, 2'h0);
      acc(8'h00); chk_bit("alloc", 1'b0, dec.allocate);
      acc(8'h40); chk_bit("alloc", 1'b0, dec.allocate);
      acc(8'hd0); chk_bit("upg", 1'b1, dec.upgrade_mod);
      acc(8'he0); chk_bit("shr", 1'b1, dec.keep_shared);
      chk_bit("upg", 1'b0, dec.upgrade_mod);
      acc(8'h80); chk_bit("mem", 1'b1, dec.to_memory);
      chk_bit("alloc", 1'b0, dec.allocate);
      snoop(1'b1); chk_bit("snp", 1'b0, snp.valid);
      chk_bit("par_n", 1'b1, pe_n);
      @(posedge clk); flush <= 1'b1; #1;
      chk_bit("l1inv", 1'b1, l1_inv);
      @(posedge clk); flush <= 1'b0;
      wr(8'h18, 32'h3, 2'h0);
      snoop(1'b1); chk_bit("snp", 1'b1, snp.valid);
      chk_bit("par_n", 1'b0, pe_n);
      chk_bit("snp_pe", 1'b1, snp.par_err);
      chk_bit("inv", 1'b0, snp.invalidate);
      snoop(1'b0); chk_bit("inv", 1'b0, snp.invalidate);
      // normal caching with paging; all regions and page types write-back
      wr(8'h00, 32'h8000_0000, 2'h0);
      wr(8'h10, 32'h0000_6666, 2'h0);
      wr(8'h14, 32'h6666_6666, 2'h0);
      rd(8'h00, 32'h8000_0000, 32'hffff_ffff, 2'h0);
      acc(8'h00); chk_bit("cach", 1'b1, dec.cacheable);
      chk_bit("wt", 1'b0, dec.write_through);
      chk_bit("alloc", 1'b1, dec.allocate);
      chk_bit("dvalid", 1'b1, dec.valid);
      chk_word("mtype", {29'h0, cpc_pkg::MT_WB}, {29'h0, dec.mtype});
      acc(8'h04); chk_bit("wt", 1'b1, dec.write_through);
      chk_bit("pinwt", 1'b1, dec.pin_pwt);
      acc(8'h08); chk_bit("cach", 1'b0, dec.cacheable);
      chk_bit("pinuc", 1'b1, dec.pin_pcd);
      wr(8'h04, 32'h10, 2'h0);
      acc(8'h01); chk_bit("cach", 1'b0, dec.cacheable);
      chk_bit("pinuc", 1'b1, dec.pin_pcd);
      acc(8'h00); chk_bit("cach", 1'b1, dec.cacheable);
      chk_bit("pinuc", 1'b0, dec.pin_pcd);
      wr(8'h04, 32'h0, 2'h0);
      acc(8'h02); chk_bit("tlb", 1'b0, dec.tlb_keep);
      wr(8'h08, 32'h80, 2'h0);
      acc(8'h02); chk_bit("tlb", 1'b1, dec.tlb_keep);
      wr(8'h0c, 32'h40, 2'h0);
      acc(8'h00); chk_bit("l3", 1'b0, dec.l3_enable);
      chk_bit("cach", 1'b1, dec.cacheable);
      wr(8'h0c, 32'h0, 2'h0);
      acc(8'h00); chk_bit("l3", 1'b1, dec.l3_enable);
      uc_m <= 1'b1;
      acc(8'h00); chk_bit("cach", 1'b0, dec.cacheable);
      uc_m <= 1'b0; wt_m <= 1'b1;
      acc(8'h00); chk_bit("wt", 1'b1, dec.write_through);
      wt_m <= 1'b0;
      wr(8'h10, 32'h0, 2'h0);
      acc(8'h00); chk_bit("cach", 1'b0, dec.cacheable);
      wr(8'h10, 32'h0000_6666, 2'h0);
      wr(8'h14, 32'h0, 2'h0);
      acc(8'h00); chk_bit("cach", 1'b0, dec.cacheable);
      // no-coherency mode absent: cache disable alone means no-fill
      wr(8'h18, 32'h0, 2'h0);
      wr(8'h00, 32'h4000_0000, 2'h0);
      rd(8'h1c, 32'h8, 32'hc, 2'h0);
      acc(8'h00); chk_bit("alloc", 1'b0, dec.allocate);
      rd(8'h20, 32'h0, 32'hffff_ffff, 2'h2);
      wr(8'h1c, 32'h1, 2'h2);
      conclude();
   end
endmodule // cache_policy_control_tb
